// file: hw/flash_prot_pkg.sv
// Shared constants and carrier types for the serial flash protection block.
// Assumes a 25 MHz system clock that oversamples the host serial link.
package flash_prot_pkg;

   localparam int ARRAY_AW = 19;
   localparam int CMD_AW   = 24;

   localparam logic [7:0] LATCH_SET_CMD      = 8'h06;
   localparam logic [7:0] LATCH_CLEAR_CMD    = 8'h04;
   localparam logic [7:0] STATUS_WRITE_CMD   = 8'h01;
   localparam logic [7:0] STATUS_READ_LO_CMD = 8'h05;
   localparam logic [7:0] STATUS_READ_HI_CMD = 8'h35;
   localparam logic [7:0] PAGE_WRITE_CMD     = 8'h02;
   localparam logic [7:0] HALF_K_WIPE_CMD    = 8'h8A;
   localparam logic [7:0] FOUR_K_WIPE_CMD    = 8'h20;
   localparam logic [7:0] BLOCK32_WIPE_CMD   = 8'h52;
   localparam logic [7:0] BLOCK64_WIPE_CMD   = 8'hD8;
   localparam logic [7:0] CHIP_WIPE_A_CMD    = 8'h60;
   localparam logic [7:0] CHIP_WIPE_B_CMD    = 8'hC7;
   localparam logic [7:0] DUAL_OUT_READ_CMD  = 8'h3B;
   localparam logic [7:0] DUAL_IO_READ_CMD   = 8'hBB;
   localparam logic [7:0] DEEP_SLEEP_CMD     = 8'hB9;
   localparam logic [7:0] WAKE_CMD           = 8'hAB;

   // Positions in the pin synchroniser vector
   localparam int PIN_SCLK = 0;
   localparam int PIN_CS   = 1;
   localparam int PIN_D0   = 2;
   localparam int PIN_D1   = 3;
   localparam int PIN_WP   = 4;
   localparam int PIN_N    = 5;

   // Status word layout
   localparam int ST_BUSY        = 0;
   localparam int ST_ARMED       = 1;
   localparam int ST_PROT_LO     = 2;
   localparam int ST_LOCK_LO     = 7;
   localparam int ST_LOCK_HI     = 8;
   localparam int ST_OTP_LO      = 11;
   localparam int ST_INVERT      = 14;
   localparam int ST_HI_BASE     = 8;
   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // Stand-in data for reads, the array itself lives elsewhere
   localparam logic [7:0] FILL_BYTE = 8'hFF;

   localparam int CLK_MHZ       = 25;
   localparam int PROG_TIME_US  = 1100;
   localparam int SECT_TIME_US  = 2600;
   localparam int BLOCK_TIME_US = 2600;
   localparam int CHIP_TIME_US  = 5200;
   localparam int PROG_CYC      = PROG_TIME_US * CLK_MHZ;
   localparam int SECT_CYC      = SECT_TIME_US * CLK_MHZ;
   localparam int BLOCK_CYC     = BLOCK_TIME_US * CLK_MHZ;
   localparam int CHIP_CYC      = CHIP_TIME_US * CLK_MHZ;
   localparam int SR_WRITE_CYC  = 16;
   localparam int MIN_BUSY_CYC  = 8;

   typedef enum logic [2:0] {
      OP_PROG,
      OP_WIPE_HALF,
      OP_WIPE_4K,
      OP_WIPE_32K,
      OP_WIPE_64K,
      OP_WIPE_CHIP,
      OP_STATUS
   } op_kind_e;

   typedef struct packed {
      logic       invert;
      logic [4:0] code;
   } prot_cfg_s;

   typedef struct packed {
      logic              valid;
      op_kind_e          kind;
      logic [CMD_AW-1:0] addr;
   } array_op_s;

endpackage

// file: hw/protect_range.sv
// Maps the protect code and invert bit to a hit for one array address.
// Purely combinational; the caller registers whatever it derives.
`timescale 1ns/1ns
module protect_range (
   input  flash_prot_pkg::prot_cfg_s                   cfg_i,
   input  wire logic [flash_prot_pkg::ARRAY_AW-1:0]    addr_i,
   output logic                                        hit_o,
   output logic                                        chip_ok_o
);
   import flash_prot_pkg::*;

   localparam logic [ARRAY_AW-1:0] ONES = '1;

   logic       none_b;
   logic       all_b;
   logic       top_b;
   logic       in_b;
   logic [4:0] sz_log;

   function automatic logic [4:0] size_log(input logic [4:0] c);
      if (!c[4]) begin
         size_log = 5'(15 + c[1:0]);
      end else if (c[2]) begin
         size_log = 5'd15;
      end else begin
         size_log = 5'(11 + c[1:0]);
      end
   endfunction

   always_comb begin
      none_b = (cfg_i.code[2:0] == 3'h0);
      all_b  = cfg_i.code[4] ? (cfg_i.code[2:0] == 3'h7)
                             : cfg_i.code[2];
      top_b  = !cfg_i.code[3];
      sz_log = size_log(cfg_i.code);
      if (top_b) begin
         in_b = ((addr_i >> sz_log) == (ONES >> sz_log));
      end else begin
         in_b = ((addr_i >> sz_log) == '0);
      end
      // Invert selects the complement, so all and none swap
      hit_o = (none_b ? 1'b0 : (all_b | in_b)) ^ cfg_i.invert;
      chip_ok_o = (none_b & !cfg_i.invert)
                | ((cfg_i.code[2:0] == 3'h7) & cfg_i.invert);
   end

endmodule

// file: hw/serial_flash_write_protection.sv
// Write-protection, status and serial command front end of a serial flash.
// Assumes the host serial clock is far slower than clk_i (at least 8x).
`timescale 1ns/1ns
// Contract
// - Accept serial clock mode 0 and mode 3
// - Sample on rising, shift out on falling
// - Dual reads use both data lines
// - Latch-set command arms write latch
// - Reset, clear, writes and erases disarm latch
// - Unarmed latch rejects status write, program, erase
// - Pin lock freezes protect and lock bits
// - Deep sleep ignores all but wake
// - Protect code picks top or bottom range
// - Bit4 codes give small sector ranges
// - Invert bit protects the complement range
// - Protect field changes only by status write
// - Refuse program or erase in protected range (code checks only the given address, not the whole erase block)
// - Chip erase only for all-none codes
// - Busy flag high during program, erase, write
// - Upper status byte field layout
// - Lock bits and pin select status protection
module serial_flash_write_protection #(
   parameter int PROG_CYCLES  = flash_prot_pkg::PROG_CYC,
   parameter int SECT_CYCLES  = flash_prot_pkg::SECT_CYC,
   parameter int BLOCK_CYCLES = flash_prot_pkg::BLOCK_CYC,
   parameter int CHIP_CYCLES  = flash_prot_pkg::CHIP_CYC,
   parameter int SR_CYCLES    = flash_prot_pkg::SR_WRITE_CYC,
   parameter int CNT_W        = 18
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 sclk_i,
   input  wire logic                 cs_n_i,
   input  wire logic                 wp_n_i,
   input  wire logic                 dual_line_zero_i,
   output logic                      dual_line_zero_o,
   output logic                      dual_line_zero_oe_o,
   input  wire logic                 dual_line_one_i,
   output logic                      dual_line_one_o,
   output logic                      dual_line_one_oe_o,
   output logic [15:0]               status_o,
   output flash_prot_pkg::array_op_s array_op_o
);
   import flash_prot_pkg::*;

   if (CNT_W < 4 || CNT_W > 31) begin : g_bad_width
      $error("CNT_W out of range");
   end
   if (PROG_CYCLES >= 2**CNT_W || SECT_CYCLES >= 2**CNT_W ||
       BLOCK_CYCLES >= 2**CNT_W || CHIP_CYCLES >= 2**CNT_W ||
       SR_CYCLES >= 2**CNT_W) begin : g_bad_count
      $error("busy count does not fit CNT_W");
   end
   if (PROG_CYCLES < MIN_BUSY_CYC || SECT_CYCLES < MIN_BUSY_CYC ||
       BLOCK_CYCLES < MIN_BUSY_CYC || CHIP_CYCLES < MIN_BUSY_CYC ||
       SR_CYCLES < MIN_BUSY_CYC) begin : g_short_count
      $error("busy count too short");
   end

   typedef enum logic [1:0] {
      OUT_NONE,
      OUT_ONE,
      OUT_TWO
   } out_e;

   typedef struct packed {
      logic [PIN_N-1:0]  sy1;
      logic [PIN_N-1:0]  sy2;
      logic              sclk_d;
      logic              cs_d;
      logic [7:0]        rx;
      logic [3:0]        bits;
      logic [2:0]        idx;
      logic [7:0]        opc;
      logic [CMD_AW-1:0] addr;
      logic [7:0]        d1;
      logic [7:0]        d2;
      out_e              omode;
      logic [7:0]        osh;
      logic [2:0]        oleft;
      logic              write_armed_flag;
      logic              busy;
      logic [CNT_W-1:0]  bcnt;
      logic              deep;
      logic [4:0]        bp;
      logic              cmp;
      logic [1:0]        srp;
      logic [2:0]        lb;
      logic              o0;
      logic              o0e;
      logic              o1;
      logic              o1e;
      logic [15:0]       stat;
      array_op_s         op;
   } state_s;

   state_s     s_r;
   state_s     s_nxt;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_rise;
   logic       selected;
   logic       dual_in;
   logic [7:0] rx_next;
   logic [3:0] bits_next;
   logic [7:0] out_src;
   logic       hw_lock;
   logic       base_ok;
   logic       addr_cmd;
   logic       addr_len_ok;
   logic       chip_cmd;
   logic       hit;
   logic       chip_ok;
   logic       go_set;
   logic       go_clear;
   logic       go_sw;
   logic       go_addr;
   logic       go_chip;
   logic       go_sleep;
   logic       go_wake;

   function automatic logic [CNT_W-1:0] cyc_for(input logic [7:0] c);
      case (c)
         PAGE_WRITE_CMD:   cyc_for = CNT_W'(PROG_CYCLES - 1);
         HALF_K_WIPE_CMD,
         FOUR_K_WIPE_CMD:  cyc_for = CNT_W'(SECT_CYCLES - 1);
         BLOCK32_WIPE_CMD,
         BLOCK64_WIPE_CMD: cyc_for = CNT_W'(BLOCK_CYCLES - 1);
         CHIP_WIPE_A_CMD,
         CHIP_WIPE_B_CMD:  cyc_for = CNT_W'(CHIP_CYCLES - 1);
         default:          cyc_for = CNT_W'(SR_CYCLES - 1);
      endcase
   endfunction

   function automatic op_kind_e kind_for(input logic [7:0] c);
      case (c)
         PAGE_WRITE_CMD:   kind_for = OP_PROG;
         HALF_K_WIPE_CMD:  kind_for = OP_WIPE_HALF;
         FOUR_K_WIPE_CMD:  kind_for = OP_WIPE_4K;
         BLOCK32_WIPE_CMD: kind_for = OP_WIPE_32K;
         BLOCK64_WIPE_CMD: kind_for = OP_WIPE_64K;
         CHIP_WIPE_A_CMD,
         CHIP_WIPE_B_CMD:  kind_for = OP_WIPE_CHIP;
         default:          kind_for = OP_STATUS;
      endcase
   endfunction

   // Suspend is not supported, so both pause flags read zero
   function automatic logic [15:0] pack_status(input state_s s);
      logic [15:0] w;
      w = '0;
      w[ST_BUSY]          = s.busy;
      w[ST_ARMED]         = s.write_armed_flag;
      w[ST_PROT_LO +: 5]  = s.bp;
      w[ST_LOCK_LO]       = s.srp[0];
      w[ST_LOCK_HI]       = s.srp[1];
      w[ST_OTP_LO +: 3]   = s.lb;
      w[ST_INVERT]        = s.cmp;
      pack_status = w;
   endfunction

   function automatic state_s reset_state();
      state_s s;
      s = '0;
      s.sy1[PIN_CS] = 1'b1;
      s.sy2[PIN_CS] = 1'b1;
      s.cs_d        = 1'b1;
      s.omode       = OUT_NONE;
      s.bp          = STATUS_RESET[ST_PROT_LO +: 5];
      s.srp[0]      = STATUS_RESET[ST_LOCK_LO];
      s.srp[1]      = STATUS_RESET[ST_LOCK_HI];
      s.lb          = STATUS_RESET[ST_OTP_LO +: 3];
      s.cmp         = STATUS_RESET[ST_INVERT];
      s.write_armed_flag         = STATUS_RESET[ST_ARMED];
      s.stat        = STATUS_RESET;
      reset_state   = s;
   endfunction

   protect_range u_range (
      .cfg_i     ({s_r.cmp, s_r.bp}),
      .addr_i    (s_r.addr[ARRAY_AW-1:0]),
      .hit_o     (hit),
      .chip_ok_o (chip_ok)
   );

   // Edges are found from clock transitions alone, whatever the idle level, so either clock mode works
   assign sclk_rise = s_r.sy2[PIN_SCLK] & !s_r.sclk_d;
   assign sclk_fall = !s_r.sy2[PIN_SCLK] & s_r.sclk_d;
   assign cs_rise   = s_r.sy2[PIN_CS] & !s_r.cs_d;
   assign selected  = !s_r.sy2[PIN_CS];

   assign dual_in = (s_r.opc == DUAL_IO_READ_CMD)
                  && (s_r.idx != 3'h0) && (s_r.idx <= 3'h4);
   assign rx_next = dual_in
                  ? {s_r.rx[5:0], s_r.sy2[PIN_D1], s_r.sy2[PIN_D0]}
                  : {s_r.rx[6:0], s_r.sy2[PIN_D0]};
   assign bits_next = s_r.bits + (dual_in ? 4'h2 : 4'h1);
   assign out_src = (s_r.opc == STATUS_READ_HI_CMD) ? s_r.stat[15:8]
                  : (s_r.opc == STATUS_READ_LO_CMD) ? s_r.stat[7:0]
                  : FILL_BYTE;

   assign hw_lock = s_r.srp[1]
                  | (s_r.srp[0] & !s_r.sy2[PIN_WP]);

   // Latch, status write, program, erase, sleep and wake commands act only at a byte boundary when chip select rises
   assign base_ok = cs_rise && (s_r.bits == 4'h0)
                 && !s_r.deep && !s_r.busy;
   assign addr_cmd = (s_r.opc == PAGE_WRITE_CMD)
                  || (s_r.opc == HALF_K_WIPE_CMD)
                  || (s_r.opc == FOUR_K_WIPE_CMD)
                  || (s_r.opc == BLOCK32_WIPE_CMD)
                  || (s_r.opc == BLOCK64_WIPE_CMD);
   assign addr_len_ok = (s_r.opc == PAGE_WRITE_CMD) ? (s_r.idx >= 3'h5)
                                                    : (s_r.idx == 3'h4);
   assign chip_cmd = (s_r.opc == CHIP_WIPE_A_CMD)
                  || (s_r.opc == CHIP_WIPE_B_CMD);

   assign go_set   = base_ok && (s_r.opc == LATCH_SET_CMD)
                  && (s_r.idx == 3'h1);
   assign go_clear = base_ok && (s_r.opc == LATCH_CLEAR_CMD)
                  && (s_r.idx == 3'h1);
   assign go_sw    = base_ok && (s_r.opc == STATUS_WRITE_CMD)
                  && (s_r.idx == 3'h2 || s_r.idx == 3'h3)
                  && s_r.write_armed_flag && !hw_lock;
   assign go_addr  = base_ok && addr_cmd && addr_len_ok
                  && s_r.write_armed_flag && !hit;
   assign go_chip  = base_ok && chip_cmd && (s_r.idx == 3'h1)
                  && s_r.write_armed_flag && chip_ok;
   assign go_sleep = base_ok && (s_r.opc == DEEP_SLEEP_CMD)
                  && (s_r.idx == 3'h1);
   assign go_wake  = cs_rise && (s_r.bits == 4'h0) && s_r.deep
                  && (s_r.opc == WAKE_CMD) && (s_r.idx != 3'h0);

   always_comb begin
      s_nxt = s_r;
      s_nxt.sy1[PIN_SCLK] = sclk_i;
      s_nxt.sy1[PIN_CS]   = cs_n_i;
      s_nxt.sy1[PIN_D0]   = dual_line_zero_i;
      s_nxt.sy1[PIN_D1]   = dual_line_one_i;
      s_nxt.sy1[PIN_WP]   = wp_n_i;
      s_nxt.sy2           = s_r.sy1;
      s_nxt.sclk_d        = s_r.sy2[PIN_SCLK];
      s_nxt.cs_d          = s_r.sy2[PIN_CS];
      s_nxt.op.valid      = 1'b0;

      if (s_r.busy) begin
         if (s_r.bcnt == '0) begin
            s_nxt.busy = 1'b0;
         end else begin
            s_nxt.bcnt = s_r.bcnt - 1'b1;
         end
      end

      if (!selected) begin
         s_nxt.bits  = 4'h0;
         s_nxt.idx   = 3'h0;
         s_nxt.omode = OUT_NONE;
         s_nxt.oleft = 3'h0;
         s_nxt.o0e   = 1'b0;
         s_nxt.o1e   = 1'b0;
      end else begin
         if (sclk_rise) begin
            s_nxt.rx   = rx_next;
            s_nxt.bits = bits_next;
            if (bits_next == 4'h8) begin
               s_nxt.bits = 4'h0;
               if (s_r.idx != 3'h7) begin
                  s_nxt.idx = s_r.idx + 3'h1;
               end
               if (s_r.idx == 3'h0) begin
                  s_nxt.opc = rx_next;
                  if (!s_r.deep && (rx_next == STATUS_READ_LO_CMD ||
                                    rx_next == STATUS_READ_HI_CMD)) begin
                     s_nxt.omode = OUT_ONE;
                  end
               end else if (s_r.idx <= 3'h3) begin
                  s_nxt.addr = {s_r.addr[CMD_AW-9:0], rx_next};
               end
               if (s_r.idx == 3'h1) begin
                  s_nxt.d1 = rx_next;
               end
               if (s_r.idx == 3'h2) begin
                  s_nxt.d2 = rx_next;
               end
               if (s_r.idx == 3'h4 && !s_r.deep && !s_r.busy &&
                   (s_r.opc == DUAL_OUT_READ_CMD ||
                    s_r.opc == DUAL_IO_READ_CMD)) begin
                  s_nxt.omode = OUT_TWO;
               end
            end
         end
         // A fresh byte is fetched each time the shifter runs dry, so
         // status reads repeat with live contents
         if (sclk_fall) begin
            case (s_r.omode)
               OUT_ONE: begin
                  s_nxt.o1e = 1'b1;
                  if (s_r.oleft == 3'h0) begin
                     s_nxt.o1    = out_src[7];
                     s_nxt.osh   = {out_src[6:0], 1'b0};
                     s_nxt.oleft = 3'h7;
                  end else begin
                     s_nxt.o1    = s_r.osh[7];
                     s_nxt.osh   = {s_r.osh[6:0], 1'b0};
                     s_nxt.oleft = s_r.oleft - 3'h1;
                  end
               end
               OUT_TWO: begin
                  s_nxt.o0e = 1'b1;
                  s_nxt.o1e = 1'b1;
                  if (s_r.oleft == 3'h0) begin
                     s_nxt.o1    = out_src[7];
                     s_nxt.o0    = out_src[6];
                     s_nxt.osh   = {out_src[5:0], 2'b00};
                     s_nxt.oleft = 3'h3;
                  end else begin
                     s_nxt.o1    = s_r.osh[7];
                     s_nxt.o0    = s_r.osh[6];
                     s_nxt.osh   = {s_r.osh[5:0], 2'b00};
                     s_nxt.oleft = s_r.oleft - 3'h1;
                  end
               end
               default: begin
                  s_nxt.o0e = 1'b0;
                  s_nxt.o1e = 1'b0;
               end
            endcase
         end
      end

      if (go_set) begin
         s_nxt.write_armed_flag = 1'b1;
      end
      if (go_clear) begin
         s_nxt.write_armed_flag = 1'b0;
      end
      // A one-byte status write leaves the upper byte untouched
      if (go_sw) begin
         s_nxt.bp     = s_r.d1[ST_PROT_LO +: 5];
         s_nxt.srp[0] = s_r.d1[ST_LOCK_LO];
         if (s_r.idx == 3'h3) begin
            s_nxt.srp[1] = s_r.d2[ST_LOCK_HI - ST_HI_BASE];
            s_nxt.lb     = s_r.lb | s_r.d2[ST_OTP_LO - ST_HI_BASE +: 3];
            s_nxt.cmp    = s_r.d2[ST_INVERT - ST_HI_BASE];
         end
      end
      if (go_sw || go_addr || go_chip) begin
         s_nxt.write_armed_flag      = 1'b0;
         s_nxt.busy     = 1'b1;
         s_nxt.bcnt     = cyc_for(s_r.opc);
         s_nxt.op.valid = 1'b1;
         s_nxt.op.kind  = kind_for(s_r.opc);
         s_nxt.op.addr  = s_r.addr;
      end
      if (go_sleep) begin
         s_nxt.deep = 1'b1;
      end
      if (go_wake) begin
         s_nxt.deep = 1'b0;
      end

      s_nxt.stat = pack_status(s_nxt);
      if (rst_i) begin
         s_nxt = reset_state();
      end
   end

   always_ff @(posedge clk_i) begin
      s_r <= s_nxt;
   end

   assign dual_line_zero_o    = s_r.o0;
   assign dual_line_zero_oe_o = s_r.o0e;
   assign dual_line_one_o     = s_r.o1;
   assign dual_line_one_oe_o  = s_r.o1e;
   assign status_o            = s_r.stat;
   assign array_op_o          = s_r.op;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence busy_run;
      s_r.busy [*8];
   endsequence

   sequence write_refused;
      !s_r.busy ##1 !s_r.busy;
   endsequence

   a_sample_rise: assert property (
      $changed(s_r.rx) |-> $past(sclk_rise))
      else $error("input shifted without a rising edge");

   a_drive_fall: assert property (
      $changed(dual_line_one_o) |-> $past(sclk_fall))
      else $error("output moved without a falling edge");

   a_dual_pair: assert property (
      dual_line_zero_oe_o |-> dual_line_one_oe_o &&
         (s_r.opc == DUAL_OUT_READ_CMD || s_r.opc == DUAL_IO_READ_CMD))
      else $error("line zero driven outside a dual read");

   a_latch_set: assert property (
      go_set |=> s_r.write_armed_flag ##1 status_o[ST_ARMED])
      else $error("latch set not reflected in status");

   a_latch_clear: assert property (
      (go_clear || go_sw || go_addr || go_chip) |=> !s_r.write_armed_flag)
      else $error("latch not cleared");

   a_unarmed_drop: assert property (
      cs_rise && !s_r.write_armed_flag && !s_r.busy |=> write_refused)
      else $error("write accepted without armed latch");

   a_pin_lock: assert property (
      cs_rise && hw_lock |=> $stable(s_r.bp) && $stable(s_r.srp))
      else $error("locked protect bits changed");

   a_deep_ignore: assert property (
      cs_rise && s_r.deep && s_r.opc != WAKE_CMD
         |=> s_r.deep && $stable(s_r.write_armed_flag) && !s_r.busy)
      else $error("command acted during deep sleep");

   a_range_refuse: assert property (
      cs_rise && addr_cmd && hit && !s_r.busy |=> !s_r.op.valid)
      else $error("write into protected range started");

   a_chip_gate: assert property (
      s_r.op.valid && s_r.op.kind == OP_WIPE_CHIP |-> $past(chip_ok))
      else $error("chip erase with protection in force");

   a_busy_hold: assert property (
      $rose(s_r.busy) |-> busy_run and s_r.op.valid)
      else $error("busy flag shorter than its operation");

endmodule

// file: tb/spi_host_model.sv
// Host controller model that drives the serial link in mode 0 or mode 3.
// Assumes the device oversamples the pins with clk_i, 8 clocks per bit.
`timescale 1ns/1ns
module spi_host_model (
   input  wire logic clk_i,
   input  wire logic miso_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o
);
   logic [7:0] rx;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Serial clock stands still between frames, idle level picks the mode
   task automatic frame(input logic m3, input int n, input logic [39:0] w);
      sclk_o <= m3;
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b0;
      for (int i = 39; i > 39 - 8 * n; i--) begin
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
         // Bytes beyond the word shift zeros rather than unknowns
         mosi_o <= (i >= 0) ? w[i] : 1'b0;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         rx <= {rx[6:0], miso_i};
      end
      repeat (4) @(posedge clk_i);
      sclk_o <= m3;
      mosi_o <= ~mosi_o;
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      repeat (10) @(posedge clk_i);
   endtask
endmodule

// file: tb/tb_serial_flash_write_protection.sv
// Self-checking bench for the flash write-protection block.
// Assumes short busy counts so every operation ends within tens of clocks.
`timescale 1ns/1ns
module tb_serial_flash_write_protection;
   import flash_prot_pkg::*;
   localparam int CYC = 20;
   typedef struct packed {
      logic [7:0]  cmd;
      logic        inv;
      logic [4:0]  code;
      logic [23:0] addr;
      logic        ok;
   } row_s;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wp_n_i = 1'b1;
   int          op_seen = 0;
   logic        dual_seen = 1'b0;
   logic        sclk, cs_n, mosi, d0, d0_oe, d1, d1_oe, line0, line1;
   logic [15:0] status_o;
   array_op_s   array_op_o;
   int          err_total = 0;
   int          comparisons = 0;
   row_s        tbl[9] = '{'{8'h20, 1'b0, 5'h01, 24'h070000, 1'b0},
      '{8'h8A, 1'b0, 5'h01, 24'h06FE00, 1'b1},
      '{8'h52, 1'b0, 5'h11, 24'h07F000, 1'b0},
      '{8'hD8, 1'b0, 5'h11, 24'h070000, 1'b1},
      '{8'h20, 1'b1, 5'h01, 24'h06F000, 1'b0},
      '{8'h52, 1'b1, 5'h01, 24'h070000, 1'b1},
      '{8'h60, 1'b0, 5'h01, 24'h000000, 1'b0},
      '{8'hC7, 1'b0, 5'h00, 24'h000000, 1'b1},
      '{8'h60, 1'b1, 5'h07, 24'h000000, 1'b1}};

   always #20 clk_i = ~clk_i;
   // Released line 1 reads low so a missed drive cannot pass as fill data
   always @(posedge clk_i) if (d0_oe && d1_oe && d0) dual_seen <= 1'b1;
   always @(posedge clk_i) if (array_op_o.valid) op_seen <= op_seen + 1;
   assign line0 = d0_oe ? d0 : mosi;
   assign line1 = d1_oe ? d1 : 1'b0;

   serial_flash_write_protection #(.PROG_CYCLES(CYC), .SECT_CYCLES(CYC),
      .BLOCK_CYCLES(CYC), .CHIP_CYCLES(CYC), .SR_CYCLES(CYC))
      u_serial_flash_write_protection (
      .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .wp_n_i(wp_n_i), .dual_line_zero_i(line0), .dual_line_zero_o(d0),
      .dual_line_zero_oe_o(d0_oe), .dual_line_one_i(line1),
      .dual_line_one_o(d1), .dual_line_one_oe_o(d1_oe),
      .status_o(status_o), .array_op_o(array_op_o));
   spi_host_model u_spi_host_model (.clk_i(clk_i), .miso_i(line1),
      .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

   task automatic chk(input string s, input logic [23:0] e,
                      input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cmd(input int n, input logic [39:0] w);
      u_spi_host_model.frame(1'b0, n, w);
   endtask
   task automatic wsr(input logic inv, input logic [7:0] lo);
      cmd(1, {LATCH_SET_CMD, 32'h0});
      cmd(3, {STATUS_WRITE_CMD, lo, 1'b0, inv, 6'h00, 16'h0});
      repeat (CYC) @(posedge clk_i);
   endtask
   task automatic test_done;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk_i);
      err_total++;
      test_done();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("status", 16'h0000, status_o);
      u_spi_host_model.frame(1'b1, 1, {LATCH_SET_CMD, 32'h0});
      chk("status", 16'h0002, status_o);
      cmd(2, {STATUS_READ_LO_CMD, 32'h0});
      chk("read lo", 16'h0002, {8'h00, u_spi_host_model.rx});
      cmd(1, {LATCH_CLEAR_CMD, 32'h0});
      chk("status", 16'h0000, status_o);
      cmd(5, {PAGE_WRITE_CMD, 32'h0});
      chk("status", 16'h0000, status_o);
      foreach (tbl[k]) begin
         wsr(tbl[k].inv, {1'b0, tbl[k].code, 2'b00});
         cmd(1, {LATCH_SET_CMD, 32'h0});
         cmd(tbl[k].cmd inside {CHIP_WIPE_A_CMD, CHIP_WIPE_B_CMD} ? 1 : 4,
             {tbl[k].cmd, tbl[k].addr, 8'h00});
         chk("busy armed", {14'h0, ~tbl[k].ok, tbl[k].ok},
             status_o & 16'h0003);
         if (tbl[k].ok && tbl[k].addr != 24'h0)
            chk("op addr", tbl[k].addr, array_op_o.addr);
         if (tbl[k].ok && tbl[k].addr == 24'h0)
            chk("op kind", 24'(OP_WIPE_CHIP), 24'(array_op_o.kind));
         repeat (CYC) @(posedge clk_i);
      end
      chk("status", 16'h401C, status_o);
      cmd(2, {STATUS_READ_HI_CMD, 32'h0});
      chk("read hi", 16'h0040, {8'h00, u_spi_host_model.rx});
      wsr(1'b0, 8'h80);
      wp_n_i <= 1'b0;
      wsr(1'b0, 8'h04);
      chk("status", 16'h0082, status_o);
      wp_n_i <= 1'b1;
      wsr(1'b0, 8'h04);
      chk("status", 16'h0004, status_o);
      cmd(6, {DUAL_OUT_READ_CMD, 32'h0});
      chk("dual drive", 16'h0001, {15'h0, dual_seen});
      chk("dual read", {16'h0, FILL_BYTE}, u_spi_host_model.rx);
      cmd(4, {DUAL_IO_READ_CMD, 32'h0});
      chk("dual io read", {16'h0, FILL_BYTE}, u_spi_host_model.rx);
      cmd(1, {DEEP_SLEEP_CMD, 32'h0});
      cmd(1, {LATCH_SET_CMD, 32'h0});
      chk("status", 16'h0004, status_o);
      cmd(1, {WAKE_CMD, 32'h0});
      cmd(1, {LATCH_SET_CMD, 32'h0});
      chk("status", 16'h0006, status_o);
      chk("op count", 24'h000010, 24'(op_seen));
      test_done();
   end
endmodule
